// ---- hdl/nibble_swap_xor_pkg.sv ----
package nibble_swap_xor_pkg;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 5;
  localparam logic [DATA_W-1:0] W_RESET = 8'h00;
  localparam logic Z_RESET = 1'b0;
  localparam logic DEST_W = 1'b0;
  localparam logic DEST_F = 1'b1;
  typedef enum logic [1:0] {
    op_none,
    nibble_swap_op,
    xor_literal_op,
    xor_file_op
  } op_e;
endpackage

// ---- hdl/nibble_swap_xor_exec.sv ----
`timescale 1ns/1ps
`default_nettype none
module nibble_swap_xor_exec
  import nibble_swap_xor_pkg::*;
(
  input  wire logic              i_mclk,
  input  wire logic              i_reset,
  input  wire op_e               i_op,
  input  wire logic              i_dest,
  input  wire logic [ADDR_W-1:0] i_faddr,
  input  wire logic [DATA_W-1:0] i_fdata,
  input  wire logic [DATA_W-1:0] i_literal,
  output logic      [DATA_W-1:0] o_w,
  output logic                   o_zero,
  output logic                   o_fwrite,
  output logic      [ADDR_W-1:0] o_fwaddr,
  output logic      [DATA_W-1:0] o_fwdata
);
  logic [DATA_W-1:0] result;
  logic              to_file;
  logic              writes_w;

  always_comb begin
    result = o_w;
    unique case (i_op)
      nibble_swap_op: result = {i_fdata[3:0], i_fdata[7:4]};
      xor_literal_op: result = o_w ^ i_literal;
      xor_file_op:    result = o_w ^ i_fdata;
      op_none:        result = o_w;
    endcase
  end

  // Literal form has no file destination, so dest is ignored there
  assign to_file  = (i_op == nibble_swap_op || i_op == xor_file_op) && i_dest == DEST_F;
  assign writes_w = i_op != op_none && !to_file;

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      o_w <= W_RESET;
    end else if (writes_w) begin
      o_w <= result;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      o_zero <= Z_RESET;
    end else if (i_op == xor_literal_op || i_op == xor_file_op) begin
      o_zero <= (result == '0);
    end
  end

  // Write port registered; the register file commits one cycle later
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      o_fwrite <= 1'b0;
      o_fwaddr <= '0;
      o_fwdata <= '0;
    end else begin
      o_fwrite <= to_file;
      o_fwaddr <= i_faddr;
      o_fwdata <= result;
    end
  end

  a_swap_value: assert property (@(posedge i_mclk) disable iff (i_reset)
    (i_op == nibble_swap_op && i_dest == DEST_F) |=>
      o_fwrite && o_fwdata == {$past(i_fdata[3:0]), $past(i_fdata[7:4])})
    else $error("swap result wrong");
  a_swap_to_w: assert property (@(posedge i_mclk) disable iff (i_reset)
    (i_op == nibble_swap_op && i_dest == DEST_W) |=>
      !o_fwrite && o_w == {$past(i_fdata[3:0]), $past(i_fdata[7:4])})
    else $error("swap to working wrong");
  a_xlit_value: assert property (@(posedge i_mclk) disable iff (i_reset)
    i_op == xor_literal_op |=> !o_fwrite && o_w == ($past(o_w) ^ $past(i_literal)))
    else $error("literal xor wrong");
  a_xfile_value: assert property (@(posedge i_mclk) disable iff (i_reset)
    (i_op == xor_file_op && i_dest == DEST_F) |=>
      o_fwdata == ($past(o_w) ^ $past(i_fdata)) && o_fwaddr == $past(i_faddr))
    else $error("file xor wrong");
  a_xfile_dest: assert property (@(posedge i_mclk) disable iff (i_reset)
    (i_op == xor_file_op) |=> o_fwrite == $past(i_dest == DEST_F)
      && (o_fwrite || o_w == ($past(o_w) ^ $past(i_fdata))))
    else $error("file xor destination wrong");
  a_zero_flag: assert property (@(posedge i_mclk) disable iff (i_reset)
    (i_op == xor_literal_op || i_op == xor_file_op) |=> o_zero == (($past(o_w) ^
      ($past(i_op) == xor_literal_op ? $past(i_literal) : $past(i_fdata))) == 8'h00))
    else $error("zero flag wrong");
  a_swap_flags: assert property (@(posedge i_mclk) disable iff (i_reset)
    i_op == nibble_swap_op |=> $stable(o_zero))
    else $error("swap changed flag");
  a_fdest_w_kept: assert property (@(posedge i_mclk) disable iff (i_reset)
    ((i_op == nibble_swap_op || i_op == xor_file_op) && i_dest == DEST_F) |=> $stable(o_w))
    else $error("working changed on file destination");

  sequence s_swap_to_file;
    i_op == nibble_swap_op && i_dest == DEST_F;
  endsequence

  sequence s_swap_to_w;
    i_op == nibble_swap_op && i_dest == DEST_W;
  endsequence

  sequence s_xfile_to_file;
    i_op == xor_file_op && i_dest == DEST_F;
  endsequence

  sequence s_xfile_to_w;
    i_op == xor_file_op && i_dest == DEST_W;
  endsequence

  sequence s_any_xor;
    i_op == xor_literal_op || i_op == xor_file_op;
  endsequence

  sequence s_idle;
    i_op == op_none;
  endsequence

  // Two literal XORs back to back: second must see the first's result
  sequence s_two_literals;
    (i_op == xor_literal_op) ##1 (i_op == xor_literal_op);
  endsequence

  // No disable here, since this one checks the reset itself
  a_reset_clears: assert property (@(posedge i_mclk)
    i_reset |=> o_w == W_RESET && o_zero == Z_RESET && !o_fwrite
      && o_fwaddr == '0 && o_fwdata == '0)
    else $error("reset values wrong");

  a_swap_file_addr: assert property (@(posedge i_mclk) disable iff (i_reset)
    s_swap_to_file |=> o_fwaddr == $past(i_faddr) && $stable(o_w))
    else $error("swap file address wrong");

  a_swap_w_low: assert property (@(posedge i_mclk) disable iff (i_reset)
    s_swap_to_w |=> o_w[3:0] == $past(i_fdata[7:4]))
    else $error("swap low nibble wrong");

  a_swap_w_high: assert property (@(posedge i_mclk) disable iff (i_reset)
    s_swap_to_w |=> o_w[7:4] == $past(i_fdata[3:0]))
    else $error("swap high nibble wrong");

  a_swap_fwdata_w: assert property (@(posedge i_mclk) disable iff (i_reset)
    s_swap_to_w |=> o_fwdata == o_w)
    else $error("swap write data differs from working");

  a_xlit_no_file: assert property (@(posedge i_mclk) disable iff (i_reset)
    i_op == xor_literal_op |=> !o_fwrite)
    else $error("literal xor wrote file");

  a_xlit_dest_ignored: assert property (@(posedge i_mclk) disable iff (i_reset)
    (i_op == xor_literal_op && i_dest == DEST_F) |=>
      !o_fwrite && o_w == ($past(o_w) ^ $past(i_literal)))
    else $error("literal xor used destination");

  a_xlit_chain: assert property (@(posedge i_mclk) disable iff (i_reset)
    s_two_literals |=> o_w == ($past(o_w, 2) ^ $past(i_literal, 2) ^ $past(i_literal)))
    else $error("chained literal xor wrong");

  a_xfile_to_w: assert property (@(posedge i_mclk) disable iff (i_reset)
    s_xfile_to_w |=> !o_fwrite && o_w == ($past(o_w) ^ $past(i_fdata)))
    else $error("file xor to working wrong");

  a_xfile_file_kept: assert property (@(posedge i_mclk) disable iff (i_reset)
    s_xfile_to_file |=> o_fwrite && $stable(o_w))
    else $error("file xor to file wrong");

  a_xfile_fwdata_w: assert property (@(posedge i_mclk) disable iff (i_reset)
    s_xfile_to_w |=> o_fwdata == o_w)
    else $error("file xor write data differs");

  a_fwaddr_follow: assert property (@(posedge i_mclk) disable iff (i_reset)
    i_op != op_none |=> o_fwaddr == $past(i_faddr))
    else $error("write address not followed");

  a_zero_set_lit: assert property (@(posedge i_mclk) disable iff (i_reset)
    (i_op == xor_literal_op && i_literal == o_w) |=> o_zero)
    else $error("zero flag not set on literal");

  a_zero_clear_lit: assert property (@(posedge i_mclk) disable iff (i_reset)
    (i_op == xor_literal_op && i_literal != o_w) |=> !o_zero)
    else $error("zero flag not cleared on literal");

  a_zero_set_file: assert property (@(posedge i_mclk) disable iff (i_reset)
    (i_op == xor_file_op && i_fdata == o_w) |=> o_zero)
    else $error("zero flag not set on file");

  a_zero_clear_file: assert property (@(posedge i_mclk) disable iff (i_reset)
    (i_op == xor_file_op && i_fdata != o_w) |=> !o_zero)
    else $error("zero flag not cleared on file");

  a_zero_after_swap: assert property (@(posedge i_mclk) disable iff (i_reset)
    s_any_xor ##1 s_swap_to_file |=> $stable(o_zero) && o_fwrite)
    else $error("swap after xor changed flag");

  a_idle_quiet: assert property (@(posedge i_mclk) disable iff (i_reset)
    s_idle |=> !o_fwrite && $stable(o_w) && $stable(o_zero))
    else $error("idle cycle changed state");

  a_fwrite_source: assert property (@(posedge i_mclk) disable iff (i_reset)
    o_fwrite |-> $past((i_op == nibble_swap_op || i_op == xor_file_op) && i_dest == DEST_F))
    else $error("file write without cause");

  a_w_change_cause: assert property (@(posedge i_mclk) disable iff (i_reset)
    $changed(o_w) |-> $past(i_op != op_none))
    else $error("working changed without op");
endmodule
`default_nettype wire

// ---- tb/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import nibble_swap_xor_pkg::*;
  logic        i_mclk = 0, i_reset = 1, i_dest = 0, o_zero, o_fwrite, z = 0, fw = 0;
  op_e         i_op = op_none;
  logic [4:0]  i_faddr = 0, o_fwaddr, fa = 0;
  logic [7:0]  i_fdata = 0, i_literal = 0, o_w, o_fwdata, w = 0, r = 0;
  logic [31:0] q;
  int          num_errors = 0, compares = 0, cyc = 0, seed = 32'hba8a52b3;
  nibble_swap_xor_exec uut (.i_mclk, .i_reset, .i_op, .i_dest, .i_faddr, .i_fdata,
    .i_literal, .o_w, .o_zero, .o_fwrite, .o_fwaddr, .o_fwdata);
  initial forever #5 i_mclk = ~i_mclk;
  task chk(input string n, input logic [7:0] s, input logic [7:0] e);
    compares++;
    if (s !== e) begin
      num_errors++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task stop_test;
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Run needs about 410 cycles; ceiling well above that
  always @(posedge i_mclk) if (++cyc == 2000) begin
    num_errors++;
    stop_test();
  end
  initial begin
    repeat (5) @(posedge i_mclk);
    i_reset <= 0;
    #1 chk("w", o_w, 8'h00);
    chk("fwrite", o_fwrite, 8'h00);
    repeat (400) begin
      @(posedge i_mclk);
      fa = i_faddr;
      fw = i_dest && (i_op == nibble_swap_op || i_op == xor_file_op);
      case (i_op)
        nibble_swap_op: r = {i_fdata[3:0], i_fdata[7:4]};
        xor_literal_op: r = w ^ i_literal;
        xor_file_op:    r = w ^ i_fdata;
        default:        r = w;
      endcase
      if (i_op == xor_literal_op || i_op == xor_file_op) z = (r == 8'h00);
      if (!fw) w = r;
      q = $random(seed);
      i_op <= op_e'(q[1:0]);
      i_dest <= q[2];
      i_faddr <= q[7:3];
      // Half the operands equal W so zero results really occur
      i_fdata <= q[8] ? w : q[23:16];
      i_literal <= q[9] ? w : q[31:24];
      #1 chk("w", o_w, w);
      chk("zero", o_zero, {7'h00, z});
      chk("fwrite", o_fwrite, {7'h00, fw});
      if (fw) chk("fwdata", o_fwdata, r);
      if (fw) chk("fwaddr", o_fwaddr, {3'h0, fa});
    end
    stop_test();
  end
endmodule
`default_nettype wire
